// ---- design/smac_top.sv ----
// What this block does
// - Slave receives and accepts master parameter request
// - Simultaneous select by both is valid access
// - Slave requests access by pulsing select low
// - Slave sends ready frame in granted access
// - Request pulse lasts at least one microsecond
// - Ready frame payload at most 29 bytes
`timescale 1ns/10ps
`include "smac_regs.svh"

module smac_top
	import smac_pkg::*;
#(
	parameter int FLOW_CYC = `SMAC_FLOW_CYC
) (
	input  wire logic       CLK,
	input  wire logic       RST_B,
	input  wire logic       SCLK,
	input  wire logic       SEL_I,
	output wire logic       SEL_O,
	output wire logic       SEL_OE,
	input  wire logic       MOSI,
	output wire logic       MISO,
	input  wire logic       FLOW_EN,
	input  wire logic       TX_REQ,
	input  wire logic [4:0] TX_LEN,
	input  wire logic [7:0] TX_DATA,
	output wire logic       TX_TAKE,
	output wire logic       TX_DONE,
	output wire logic [7:0] RX_DATA,
	output wire logic       RX_VALID,
	input  wire logic       RX_READY,
	output wire logic       RX_OVERRUN,
	output wire logic       FRAME_DONE,
	output wire logic       BUSY
);

	localparam int T2_CYC = `SMAC_T2_CYC;
	localparam int SET_CYC = `SMAC_SETTLE_CYC;

	smac_core_type s_ff;
	smac_core_type nxt_s;
	smac_beat_type push;
	logic [7:0]    rx_byte;
	logic          rx_tgl;
	logic          buf_in_ready;
	logic          byte_ev;
	logic          line_low;
	logic          in_frame;
	logic          go_xfer;
	logic [5:0]    nxt_slot;
	logic [4:0]    cap_len;

	// ----------------------------------------
	// link side and receive buffer
	// ----------------------------------------
	smac_link u_link (
		.sclk     (SCLK),
		.sel_idle (SEL_I),
		.mosi     (MOSI),
		.tx_byte  (s_ff.tx_byte),
		.miso     (MISO),
		.rx_byte  (rx_byte),
		.rx_tgl   (rx_tgl)
	);

	smac_buf2 #(
		.W (8)
	) u_rxbuf (
		.clk       (CLK),
		.rst_b     (RST_B),
		.in_valid  (push.valid),
		.in_data   (push.data),
		.in_ready  (buf_in_ready),
		.out_valid (RX_VALID),
		.out_data  (RX_DATA),
		.out_ready (RX_READY)
	);

	// ----------------------------------------
	// decoded conditions
	// ----------------------------------------
	// synchronised select view
	assign line_low = !s_ff.sel_sy[1];
	// extra stage so a frame-end toggle clear lands after leaving the frame
	assign byte_ev  = s_ff.tgl_sy[3] ^ s_ff.tgl_sy[2];
	assign in_frame = (s_ff.st == SMAC_XFER) || (s_ff.st == SMAC_FLOW);
	assign nxt_slot = {1'b0, s_ff.idx} + 6'h01;
	assign cap_len  = (TX_LEN > 5'(`SMAC_LINK_PAYLOAD_UNIT_MAX)) ? 5'(`SMAC_LINK_PAYLOAD_UNIT_MAX) : TX_LEN;

	always_comb begin
		push.valid = byte_ev && in_frame;
		push.data  = rx_byte;
	end

	// ----------------------------------------
	// handshake state machine
	// ----------------------------------------
	always_comb begin
		nxt_s        = s_ff;
		nxt_s.take   = 1'b0;
		nxt_s.done   = 1'b0;
		nxt_s.txd    = 1'b0;
		nxt_s.sel_sy = {s_ff.sel_sy[0], SEL_I};
		nxt_s.tgl_sy = {s_ff.tgl_sy[2:0], rx_tgl};
		go_xfer      = 1'b0;
		case (s_ff.st)
			SMAC_IDLE: begin
				nxt_s.sel_drv = 1'b0;
				if (line_low) begin
					go_xfer = 1'b1; // master-initiated access
				end else if (TX_REQ) begin
					nxt_s.st      = SMAC_REQ;
					nxt_s.cnt     = '0;
					nxt_s.sel_drv = 1'b1;
				end
			end
			SMAC_REQ: begin
				nxt_s.cnt = s_ff.cnt + 17'h00001;
				if (s_ff.cnt == 17'(T2_CYC - 1)) begin
					nxt_s.st      = SMAC_WAIT;
					nxt_s.cnt     = '0;
					nxt_s.sel_drv = 1'b0;
				end
			end
			SMAC_WAIT: begin
				// line still low means master already selected
				if (s_ff.cnt < 17'(SET_CYC)) begin
					nxt_s.cnt = s_ff.cnt + 17'h00001;
				end else if (line_low) begin
					go_xfer = 1'b1;
				end
			end
			SMAC_XFER: begin
				if (s_ff.cnt < 17'(SET_CYC)) begin
					nxt_s.cnt = s_ff.cnt + 17'h00001;
				end else if (!line_low) begin
					nxt_s.st   = SMAC_IDLE;
					nxt_s.done = 1'b1;
					nxt_s.txd  = s_ff.sent;
					nxt_s.sent = 1'b0;
				end
				// hold select low after first data
				if (byte_ev && !s_ff.flowed && (FLOW_EN || !buf_in_ready)) begin
					nxt_s.st      = SMAC_FLOW;
					nxt_s.cnt     = '0;
					nxt_s.sel_drv = 1'b1;
					nxt_s.flowed  = 1'b1;
					nxt_s.done    = 1'b0;
					nxt_s.txd     = 1'b0;
					nxt_s.sent    = s_ff.sent;
				end
			end
			SMAC_FLOW: begin
				nxt_s.cnt = s_ff.cnt + 17'h00001;
				if (s_ff.cnt == 17'(FLOW_CYC - 1)) begin
					nxt_s.st      = SMAC_XFER;
					nxt_s.cnt     = '0;
					nxt_s.sel_drv = 1'b0;
				end
			end
			default: begin
				nxt_s.st      = SMAC_IDLE;
				nxt_s.sel_drv = 1'b0;
			end
		endcase
		// ready frame loaded at access start
		if (go_xfer) begin
			nxt_s.st      = SMAC_XFER;
			nxt_s.cnt     = '0;
			nxt_s.idx     = '0;
			nxt_s.flowed  = 1'b0;
			nxt_s.sent    = TX_REQ;
			nxt_s.len     = cap_len;
			nxt_s.tx_byte = TX_REQ ? {3'h0, cap_len} : 8'h00;
		end
		// next payload byte after each byte done
		if (byte_ev && in_frame) begin
			if (s_ff.idx != 5'h1F) begin
				nxt_s.idx = s_ff.idx + 5'h01;
			end
			if (s_ff.sent && (nxt_slot <= {1'b0, s_ff.len})) begin
				nxt_s.tx_byte = TX_DATA;
				nxt_s.take    = 1'b1;
			end else begin
				nxt_s.tx_byte = 8'h00;
			end
			if (!buf_in_ready) begin
				nxt_s.ovr = 1'b1; // sticky until reset
			end
		end
		// busy registered so the pin comes straight from a flop
		nxt_s.busy = (nxt_s.st != SMAC_IDLE);
	end

	always_ff @(posedge CLK) begin
		if (!RST_B) begin
			// select sync starts at idle level: no false access after reset
			s_ff        <= '0;
			s_ff.sel_sy <= `SMAC_SEL_SY_RST;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// ----------------------------------------
	// outputs, all from flops except the constant SEL_O
	// ----------------------------------------
	assign SEL_O      = 1'b0; // open drain: only ever pulls low
	assign SEL_OE     = s_ff.sel_drv;
	assign TX_TAKE    = s_ff.take;
	assign TX_DONE    = s_ff.txd;
	assign RX_OVERRUN = s_ff.ovr;
	assign FRAME_DONE = s_ff.done;
	assign BUSY       = s_ff.busy;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RST_B);

	sequence s_req_enter;
		(s_ff.st == SMAC_IDLE) ##1 (s_ff.st == SMAC_REQ);
	endsequence

	sequence s_flow_enter;
		(s_ff.st == SMAC_XFER) ##1 (s_ff.st == SMAC_FLOW);
	endsequence

	a_req_pulse_drive: assert property (s_req_enter |-> SEL_OE [*8])
		else $error("request pulse dropped early");

	a_req_pulse_width: assert property (
		(s_ff.st == SMAC_REQ && nxt_s.st == SMAC_WAIT) |-> s_ff.cnt == 17'(T2_CYC - 1))
		else $error("request pulse width wrong");

	a_flow_hold_low: assert property (s_flow_enter |-> SEL_OE [*8])
		else $error("flow hold released early");

	a_flow_hold_end: assert property (
		(s_ff.st == SMAC_FLOW ##1 s_ff.st == SMAC_XFER) |-> $past(s_ff.cnt) == 17'(FLOW_CYC - 1))
		else $error("flow hold length wrong");

	a_len_capped: assert property (s_ff.len <= 5'(`SMAC_LINK_PAYLOAD_UNIT_MAX))
		else $error("payload length above limit");

	a_grant_access: assert property (
		(s_ff.st == SMAC_WAIT && s_ff.cnt == 17'(SET_CYC) && line_low) |=> s_ff.st == SMAC_XFER)
		else $error("granted access not taken");

	a_sync_select: assert property (
		(s_ff.st == SMAC_IDLE ##1 s_ff.st == SMAC_XFER) |-> $past(SEL_I, 3) == 1'b0)
		else $error("access taken on unsynchronised select");

	a_take_spacing: assert property (TX_TAKE |=> !TX_TAKE [*2])
		else $error("payload bytes taken too fast");

	a_overrun_flag: assert property (
		(push.valid && !buf_in_ready) |=> RX_OVERRUN)
		else $error("lost byte not flagged");

	sequence s_frame_end;
		(s_ff.st == SMAC_XFER) ##1 (s_ff.st == SMAC_IDLE);
	endsequence

	a_done_on_release: assert property (s_frame_end |-> FRAME_DONE)
		else $error("frame end not reported");

	a_req_on_demand: assert property (
		(s_ff.st == SMAC_IDLE && !line_low && TX_REQ) |=> (SEL_OE && BUSY))
		else $error("request pulse not started");

	a_idle_no_drive: assert property ((s_ff.st == SMAC_IDLE) |-> !SEL_OE)
		else $error("select pulled while idle");

	a_wait_released: assert property ((s_ff.st == SMAC_WAIT) |-> !SEL_OE)
		else $error("select still pulled after request");

	a_take_in_len: assert property (TX_TAKE |-> (s_ff.idx <= s_ff.len))
		else $error("payload byte taken beyond length");

	a_overrun_sticky: assert property (RX_OVERRUN |=> RX_OVERRUN)
		else $error("overrun flag cleared");

	a_flow_start: assert property (
		(byte_ev && FLOW_EN && s_ff.st == SMAC_XFER && !s_ff.flowed) |=> SEL_OE)
		else $error("flow hold not started");

endmodule

// ---- design/smac_regs.svh ----
`ifndef SMAC_REGS_SVH
`define SMAC_REGS_SVH

// ----------------------------------------
// timing, in nanoseconds and in CLK cycles
// ----------------------------------------
`define SMAC_CLK_NS     8
`define SMAC_T2_NS      1000
`define SMAC_T2_CYC     ((`SMAC_T2_NS + `SMAC_CLK_NS - 1) / `SMAC_CLK_NS)
`define SMAC_FLOW_NS    450000
`define SMAC_FLOW_CYC   ((`SMAC_FLOW_NS + `SMAC_CLK_NS - 1) / `SMAC_CLK_NS)
`define SMAC_SETTLE_CYC 3

// ----------------------------------------
// frame limits and reset values
// ----------------------------------------
`define SMAC_LINK_PAYLOAD_UNIT_MAX   29
`define SMAC_MISO_RST   1'b0
`define SMAC_SEL_SY_RST 2'h3

`endif

// ---- design/smac_pkg.sv ----
package smac_pkg;

	// ----------------------------------------
	// handshake states, gray along the path
	// ----------------------------------------
	typedef enum logic [2:0] {
		SMAC_IDLE = 3'h0,
		SMAC_REQ  = 3'h1,
		SMAC_WAIT = 3'h3,
		SMAC_XFER = 3'h2,
		SMAC_FLOW = 3'h6
	} smac_state_type;

	// one received byte on its way to the buffer
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} smac_beat_type;

	// whole state of the system-clock side
	typedef struct packed {
		smac_state_type st;
		logic [16:0]    cnt;
		logic [4:0]     len;
		logic [4:0]     idx;
		logic [7:0]     tx_byte;
		logic           sel_drv;
		logic           flowed;
		logic           sent;
		logic           take;
		logic           done;
		logic           txd;
		logic           ovr;
		logic           busy;
		logic [1:0]     sel_sy;
		logic [3:0]     tgl_sy;
	} smac_core_type;

	// state of the serial-clock side
	typedef struct packed {
		logic [2:0] cnt;
		logic [6:0] sh;
		logic [7:0] rx;
		logic       tgl;
	} smac_link_type;

endpackage

// ---- design/smac_buf2.sv ----
`timescale 1ns/10ps

module smac_buf2 #(
	parameter int W = 8
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output wire logic         in_ready,
	output wire logic         out_valid,
	output wire logic [W-1:0] out_data,
	input  wire logic         out_ready
);

	typedef struct packed {
		logic         out_v;
		logic [W-1:0] out_d;
		logic         sk_v;
		logic [W-1:0] sk_d;
	} smac_buf_type;

	smac_buf_type s_ff;
	smac_buf_type nxt_s;

	// ----------------------------------------
	// two entries: output stage plus skid
	// ----------------------------------------
	always_comb begin
		nxt_s = s_ff;
		if (out_ready && s_ff.out_v) begin
			nxt_s.out_v = s_ff.sk_v;
			nxt_s.out_d = s_ff.sk_d;
			nxt_s.sk_v  = 1'b0;
		end
		if (in_valid && !s_ff.sk_v) begin
			if (!nxt_s.out_v) begin
				nxt_s.out_v = 1'b1;
				nxt_s.out_d = in_data;
			end else begin
				nxt_s.sk_v = 1'b1;
				nxt_s.sk_d = in_data;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign in_ready  = !s_ff.sk_v; // full only when skid holds a word
	assign out_valid = s_ff.out_v;
	assign out_data  = s_ff.out_d;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	a_buf_keeps_word: assert property (@(posedge clk) disable iff (!rst_b)
		(in_valid && in_ready) |=> out_valid)
		else $error("accepted word not visible at output");

endmodule

// ---- design/smac_link.sv ----
`timescale 1ns/10ps
`include "smac_regs.svh"

module smac_link
	import smac_pkg::*;
(
	input  wire logic       sclk,
	input  wire logic       sel_idle,
	input  wire logic       mosi,
	input  wire logic [7:0] tx_byte,
	output wire logic       miso,
	output wire logic [7:0] rx_byte,
	output wire logic       rx_tgl
);

	smac_link_type s_ff;
	smac_link_type nxt_s;
	logic          miso_ff;

	// ----------------------------------------
	// sample side, falling edge of the clock
	// ----------------------------------------
	always_comb begin
		nxt_s     = s_ff;
		nxt_s.sh  = {s_ff.sh[5:0], mosi};
		nxt_s.cnt = s_ff.cnt + 3'h1;
		if (s_ff.cnt == 3'h7) begin
			nxt_s.rx  = {s_ff.sh, mosi};
			nxt_s.tgl = !s_ff.tgl; // one toggle per byte
		end
	end

	// the released select ends the frame; clock may stop right after
	always_ff @(negedge sclk or posedge sel_idle) begin
		if (sel_idle) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	// launch side: next bit on the rising edge
	always_ff @(posedge sclk or posedge sel_idle) begin
		if (sel_idle) begin
			miso_ff <= `SMAC_MISO_RST;
		end else begin
			miso_ff <= tx_byte[3'h7 - s_ff.cnt];
		end
	end

	assign miso    = miso_ff;
	assign rx_byte = s_ff.rx;
	assign rx_tgl  = s_ff.tgl;

endmodule

// ---- test/smac_master.sv ----
`timescale 1ns/10ps

module smac_master #(
	parameter int XFER_DLY_NS = 2000
) (
	output logic      sclk,
	output logic      sel_drv,
	output logic      mosi,
	output logic      pwr,
	input  wire logic miso,
	input  wire logic sel_line
);
	logic [7:0] sent[$];
	logic [7:0] got[$];

	// ----------------------------------------
	// link master behaviour
	// ----------------------------------------
	// idle and unpowered at start
	initial begin
		sclk = 1'h0;
		sel_drv = 1'h0;
		mosi = 1'h0;
		pwr = 1'h0;
	end

	task automatic power_on();
		pwr = 1'h1;
		#1000;
	endtask

	// one access of n bytes, mode with mosi sampled on falling edge
	task automatic xfer(input int n);
		logic [7:0] b;
		logic [7:0] r;
		sent.delete();
		got.delete();
		sel_drv = 1'h1;
		#(XFER_DLY_NS + 10);
		for (int i = 0; i < n; i++) begin
			b = 8'($urandom);
			sent.push_back(b);
			for (int j = 7; j >= 0; j--) begin
				mosi = b[j];
				#40 sclk = 1'h1;
				#80 sclk = 1'h0;
				r = {r[6:0], miso};
				#40;
			end
			got.push_back(r);
			#80;
		end
		mosi = ~mosi;
		#80 sel_drv = 1'h0;
		wait (sel_line === 1'h1);
	endtask

	task automatic power_off();
		sel_drv = 1'h0;
		sclk = 1'h0;
		mosi = 1'h0;
		pwr = 1'h0;
	endtask
endmodule

// ---- test/tb.sv ----
`timescale 1ns/10ps
`include "smac_regs.svh"

module tb;
	localparam int FLOW = 40;
	logic       CLK, RST_B, FLOW_EN, TX_REQ, RX_READY, hold, tk_d;
	logic [4:0] TX_LEN;
	logic [7:0] TX_DATA, base;
	logic [7:0] rxq[$];
	wire logic  SCLK, MOSI, MISO, SEL_O, SEL_OE, m_sel, pwr, TX_TAKE, TX_DONE;
	wire logic  RX_VALID, RX_OVERRUN, FRAME_DONE, BUSY;
	wire logic [7:0] RX_DATA;
	int         miscompares, n_checks, run, last_run, nfd, ntd;

	// wired-low select line with pull-up
	wire logic  sel_line = ~(m_sel | (SEL_OE & ~SEL_O));

	smac_top #(.FLOW_CYC(FLOW)) dut_u (.CLK(CLK), .RST_B(RST_B), .SCLK(SCLK),
		.SEL_I(sel_line), .SEL_O(SEL_O), .SEL_OE(SEL_OE), .MOSI(MOSI), .MISO(MISO),
		.FLOW_EN(FLOW_EN), .TX_REQ(TX_REQ), .TX_LEN(TX_LEN), .TX_DATA(TX_DATA),
		.TX_TAKE(TX_TAKE), .TX_DONE(TX_DONE), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
		.RX_READY(RX_READY), .RX_OVERRUN(RX_OVERRUN), .FRAME_DONE(FRAME_DONE), .BUSY(BUSY));

	smac_master mst_u (.sclk(SCLK), .sel_drv(m_sel), .mosi(MOSI), .pwr(pwr), .miso(MISO),
		.sel_line(sel_line));

	always #4 CLK = ~CLK;

	// monitors, payload feed and random consumer stalls
	always @(posedge CLK) begin
		if (RX_VALID === 1'h1 && RX_READY === 1'h1) rxq.push_back(RX_DATA);
		nfd += (FRAME_DONE === 1'h1);
		ntd += (TX_DONE === 1'h1);
		if (SEL_OE === 1'h1) run++;
		else if (run != 0) begin
			last_run = run;
			run = 0;
		end
		#1;
		if (TX_DONE === 1'h1) TX_REQ = 1'h0;
		if (tk_d) TX_DATA = TX_DATA + 8'h01;
		tk_d = (TX_TAKE === 1'h1);
		RX_READY = !hold && ($urandom % 4 != 0);
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic cyc(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask

	task automatic chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_checks++;
		if (g !== e) begin
			miscompares++;
			$display("[FAIL] %0t %s: got %0h exp %0h", $time, m, g, e);
		end
	endtask

	task automatic wait_oe(input logic lvl);
		for (int i = 0; i < 400 && SEL_OE !== lvl; i++) cyc(1);
	endtask

	task automatic check_rx();
		cyc(20);
		chk(BUSY, 1'h0, "idle after access");
		chk(rxq.size(), mst_u.sent.size(), "rx byte count");
		foreach (mst_u.sent[k]) chk(rxq[k], mst_u.sent[k], "rx byte");
	endtask

	task automatic end_sim();
		$display("checks %0d, mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	// slave request, optionally met by a master select during the pulse
	task automatic frame(input logic [4:0] len, input logic simul);
		int n;
		int el;
		logic [7:0] e;
		el = (len > `SMAC_LINK_PAYLOAD_UNIT_MAX) ? `SMAC_LINK_PAYLOAD_UNIT_MAX : int'(len);
		n = el + 2;
		base = 8'($urandom);
		TX_DATA = base;
		TX_LEN = len;
		rxq.delete();
		ntd = 0;
		TX_REQ = 1'h1;
		wait_oe(1'h1);
		fork
			begin
				if (!simul) wait_oe(1'h0);
				mst_u.xfer(n);
			end
			begin
				wait_oe(1'h0);
				cyc(1);
				chk(last_run, `SMAC_T2_CYC, "request pulse length");
			end
		join
		for (int i = 0; i < 50 && ntd == 0; i++) cyc(1);
		TX_REQ = 1'h0;
		chk(ntd, 1, "tx done pulse");
		for (int k = 0; k < n; k++) begin
			e = (k == 0) ? 8'(el) : (k <= el) ? 8'(base + k - 1) : 8'h00;
			chk(mst_u.got[k], e, "ready frame byte");
		end
		check_rx();
		$display("test frame len %0d simul %0d done", len, simul);
	endtask

	// master access with or without flow control
	task automatic plain(input int n, input logic fl);
		FLOW_EN = fl;
		rxq.delete();
		nfd = 0;
		last_run = 0;
		mst_u.xfer(n);
		check_rx();
		chk(nfd, 1, "frame done pulse");
		chk(mst_u.got[0], 8'h00, "idle length byte");
		if (fl) chk(last_run, FLOW, "flow hold length");
		FLOW_EN = 1'h0;
		$display("test plain n %0d flow %0d done", n, fl);
	endtask

	// fill buffer past refusal, then drain it
	task automatic overrun();
		hold = 1'h1;
		cyc(2);
		rxq.delete();
		mst_u.xfer(4);
		cyc(10);
		chk(RX_OVERRUN, 1'h1, "overrun flag");
		chk(RX_VALID, 1'h1, "held word");
		hold = 1'h0;
		cyc(30);
		chk(rxq.size(), 2, "drained count");
		chk(rxq[0], mst_u.sent[0], "drained first");
		chk(rxq[1], mst_u.sent[1], "drained second");
		chk(RX_VALID, 1'h0, "buffer empty");
		$display("test overrun done");
	endtask

	// main sequence
	initial begin
		CLK = 1'h0;
		RST_B = 1'h0;
		FLOW_EN = 1'h0;
		TX_REQ = 1'h0;
		TX_LEN = 5'h00;
		TX_DATA = 8'h00;
		RX_READY = 1'h0;
		hold = 1'h0;
		tk_d = 1'h0;
		void'($urandom(32'hE0B1));
		cyc(16);
		RST_B = 1'h1;
		cyc(5);
		chk(BUSY, 1'h0, "idle after reset");
		chk(nfd, 0, "no access after reset");
		chk(SEL_OE, 1'h0, "select free after reset");
		mst_u.power_on();
		plain(1 + $urandom % 4, 1'h0);
		plain(3, 1'h1);
		frame(5'h00, 1'h0);
		frame(5'h1F, 1'h0);
		frame(5'($urandom % 30), 1'h1); // slave request met by master select during the pulse
		frame(5'($urandom % 30), 1'h0);
		overrun();
		mst_u.power_off();
		end_sim();
	end

	// watchdog
	initial begin
		#600000;
		miscompares++;
		$display("[FAIL] %0t watchdog expired", $time);
		end_sim();
	end
endmodule
